// *** aff_consts.svh ***
/*
 * Offsets, field positions, reset values and limits of the fault flag block.
 * Assumes inclusion by bare name from the design modules and the assertion module.
 */
`ifndef AFF_CONSTS_SVH
`define AFF_CONSTS_SVH

// ==========================================================
// Register offsets
// ==========================================================
`define AFF_ERR_OFS 8'h24
`define AFF_WARN_OFS 8'h26
`define AFF_TEMP_OFS 8'h28

// ==========================================================
// Register identifier codes, bits 15:12
// ==========================================================
`define AFF_ERR_ID 4'hA
`define AFF_WARN_ID 4'hB
`define AFF_TEMP_ID 4'hF

// ==========================================================
// Error word bit positions
// ==========================================================
`define AFF_ERR_RST_BIT 0
`define AFF_ERR_LOW_BIT 1
`define AFF_ERR_UVA_BIT 2
`define AFF_ERR_RESET_VAL 3'h1

// ==========================================================
// Warning word bit positions
// ==========================================================
`define AFF_W_TOV_BIT 0
`define AFF_W_HIGH_BIT 1
`define AFF_W_OVF_BIT 2
`define AFF_W_TCW_BIT 3
`define AFF_W_SAT_BIT 4
`define AFF_W_ESE_BIT 5
`define AFF_W_TR_BIT 6
`define AFF_W_XEE_BIT 7
`define AFF_W_SRW_BIT 8
`define AFF_W_CRC_BIT 10
`define AFF_W_IER_BIT 11

// ==========================================================
// Limits and thresholds
// ==========================================================
`define AFF_FIELD_LO_DEF 12'h0C8
`define AFF_FIELD_HI_DEF 12'h4B0
`define AFF_TEMP_MIN 12'hD58
`define AFF_TEMP_MAX 12'h4D8
`define AFF_TCW_LIMIT 12'h600
`define AFF_TURN_MAX_HALF 12'h1FF
`define AFF_TURN_MIN_HALF 12'hE00
`define AFF_TURN_MAX_EIGHTH 12'h7FF
`define AFF_TURN_MIN_EIGHTH 12'h800
`define AFF_PKT_BITS 6'h10
`define AFF_PKT_BITS_CRC 6'h14

`endif

// *** aff_pkg.sv ***
/*
 * Types of the fault flag block.
 * Widths of its fields are written out, not taken from aff_consts.svh.
 */
package aff_pkg;

    typedef enum logic [0:0] {
        AFF_RES_HALF = 1'b0,
        AFF_RES_EIGHTH = 1'b1
    } aff_turn_res_t;

    typedef struct packed {
        logic [2:0] uv_sync;
        logic uv_level;
        logic [11:0] tc_prev;
        logic tc_prev_valid;
        logic [11:0] lo_lim;
        logic [11:0] hi_lim;
        logic [15:0] rd_data;
    } aff_main_st_t;

    typedef struct packed {
        logic [11:0] temp;
        logic oor;
    } aff_temp_st_t;

endpackage : aff_pkg

// *** aff_sticky.sv ***
/*
 * Bank of sticky flags: set wins over clear, reset loads a constant.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/1ps

module aff_sticky #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Events and clears
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    // Flags
    output logic [W-1:0] flags
);

    initial begin
        if (W < 1) $error("aff_sticky: W must be at least 1");
    end

    logic [W-1:0] st_q;
    logic [W-1:0] st_d;

    always_comb begin
        st_d = (st_q & ~clr) | set;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) st_q <= RST_VAL;
        else st_q <= st_d;
    end

    assign flags = st_q;

endmodule : aff_sticky

// *** aff_temp.sv ***
/*
 * Temperature readout: saturates the converted value at the range limits
 * and flags an out-of-range sample. Assumes raw samples are signed eighths
 * of a degree relative to 25 C, wider than the readout.
 */
`timescale 1ns/1ps
`include "aff_consts.svh"

module aff_temp #(
    parameter int RAW_W = 14
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Raw samples
    input wire logic temp_valid,
    input wire logic [RAW_W-1:0] temp_raw,
    // Readout
    output logic [11:0] temp_out,
    output logic temp_oor
);

    initial begin
        if (RAW_W < 12) $error("aff_temp: RAW_W must be at least 12");
    end

    aff_pkg::aff_temp_st_t st_q;
    aff_pkg::aff_temp_st_t st_d;
    logic signed [RAW_W-1:0] lo_ext;
    logic signed [RAW_W-1:0] hi_ext;

    assign lo_ext = RAW_W'($signed(`AFF_TEMP_MIN));
    assign hi_ext = RAW_W'($signed(`AFF_TEMP_MAX));

    always_comb begin
        st_d = st_q;
        st_d.oor = 1'b0;
        if (temp_valid) begin
            if ($signed(temp_raw) < lo_ext) begin
                st_d.temp = `AFF_TEMP_MIN;
                st_d.oor = 1'b1;
            end else if ($signed(temp_raw) > hi_ext) begin
                st_d.temp = `AFF_TEMP_MAX;
                st_d.oor = 1'b1;
            end else begin
                st_d.temp = temp_raw[11:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) st_q <= '0;
        else st_q <= st_d;
    end

    assign temp_out = st_q.temp;
    assign temp_oor = st_q.oor;

endmodule : aff_temp

// *** aff_fault_flags.sv ***
/*
 * Latched error and warning flags of the angle sensor, with the warning,
 * temperature and error readout words on a simple register read port.
 * Assumes event inputs come from logic on clk, except the analog
 * undervoltage comparator, which is asynchronous and synchronised here.
 */
`timescale 1ns/1ps
`include "aff_consts.svh"

module aff_fault_flags #(
    parameter int TEMP_RAW_W = 14,
    parameter int SAT_W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register read and clear port
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [15:0] rd_data,
    input wire logic clr_err,
    input wire logic clr_warn,
    input wire logic turns_reset_cmd,
    // Error word bits held elsewhere
    input wire logic [8:0] err_upper,
    // Analog undervoltage comparator
    input wire logic analog_undervolt_pin,
    // Self-test
    input wire logic lbist_active,
    // Field measurement
    input wire logic field_valid,
    input wire logic [11:0] field_mag,
    // Nonvolatile configuration
    input wire logic nvm_load_active,
    input wire logic nvm_load_done,
    input wire logic [11:0] cfg_field_low_limit,
    input wire logic [11:0] cfg_field_high_limit,
    input wire logic rx_crc_check_en,
    input wire logic nvm_single_corrected,
    // Serial packet checks
    input wire logic pkt_done,
    input wire logic [5:0] pkt_bits,
    input wire logic pkt_mosi_b15,
    input wire logic pkt_manchester_err,
    input wire logic pkt_crc_bad,
    output logic pkt_accept,
    // Quadrature output slew limiting
    input wire logic slew_limit_en,
    input wire logic slew_limit_needed,
    // Extended access engine
    input wire logic ext_start,
    input wire logic ext_busy,
    input wire logic ext_cmd_done,
    input wire logic ext_locked,
    input wire logic ext_nvm_fail,
    // Signal chain saturation
    input wire logic [SAT_W-1:0] sat_stage,
    // Turns counter
    input wire logic low_power_state,
    input wire logic awake_sample,
    input wire logic [11:0] zcd_angle,
    input wire logic turn_res,
    input wire logic [11:0] turn_count,
    input wire logic turn_step_up,
    input wire logic turn_step_dn,
    // Temperature conversion
    input wire logic temp_valid,
    input wire logic [TEMP_RAW_W-1:0] temp_raw,
    // Flag outputs
    output logic [2:0] err_low_flags,
    output logic [11:0] warn_flags
);

    // ==========================================================
    // Parameter checks
    // ==========================================================
    initial begin
        if (TEMP_RAW_W < 12) $error("aff_fault_flags: TEMP_RAW_W below 12");
        if (SAT_W < 1) $error("aff_fault_flags: SAT_W below 1");
    end

    // ==========================================================
    // State
    // ==========================================================
    aff_pkg::aff_main_st_t st_q;
    aff_pkg::aff_main_st_t st_d;

    logic [2:0] err_set;
    logic [2:0] err_clr;
    logic [2:0] err_q;
    logic [11:0] warn_set;
    logic [11:0] warn_clr;
    logic [11:0] warn_q;
    logic [11:0] temp_word;
    logic temp_oor;

    // ==========================================================
    // Packet checks
    // ==========================================================
    logic len_bad;
    logic crc_fail;
    logic ifc_fail;

    assign len_bad = (pkt_bits != `AFF_PKT_BITS) && (pkt_bits != `AFF_PKT_BITS_CRC);
    assign crc_fail = rx_crc_check_en && pkt_crc_bad;
    assign ifc_fail = len_bad || pkt_mosi_b15 || pkt_manchester_err;
    // Accepted packets pass on; failing ones are dropped
    assign pkt_accept = pkt_done && !ifc_fail && !crc_fail;

    // ==========================================================
    // Field thresholds
    // ==========================================================
    logic field_low;
    logic field_high;

    assign field_low = field_valid && (field_mag < st_q.lo_lim);
    assign field_high = field_valid && (field_mag > st_q.hi_lim);

    // ==========================================================
    // Awake-to-awake angle change
    // ==========================================================
    logic [11:0] tc_delta;
    logic [11:0] tc_abs;
    logic tc_fast;

    assign tc_delta = zcd_angle - st_q.tc_prev;
    assign tc_abs = tc_delta[11] ? 12'(~tc_delta + 12'h001) : tc_delta;
    assign tc_fast = low_power_state && awake_sample && st_q.tc_prev_valid
                     && (tc_abs > `AFF_TCW_LIMIT);

    // ==========================================================
    // Turns overflow
    // ==========================================================
    logic [11:0] turn_max;
    logic [11:0] turn_min;
    logic turn_ovf;

    always_comb begin
        case (aff_pkg::aff_turn_res_t'(turn_res))
            aff_pkg::AFF_RES_HALF: begin
                turn_max = `AFF_TURN_MAX_HALF;
                turn_min = `AFF_TURN_MIN_HALF;
            end
            aff_pkg::AFF_RES_EIGHTH: begin
                turn_max = `AFF_TURN_MAX_EIGHTH;
                turn_min = `AFF_TURN_MIN_EIGHTH;
            end
            default: begin
                turn_max = `AFF_TURN_MAX_HALF;
                turn_min = `AFF_TURN_MIN_HALF;
            end
        endcase
    end

    // Stepping past either end of the count range
    assign turn_ovf = (turn_step_up && (turn_count == turn_max))
                      || (turn_step_dn && (turn_count == turn_min));

    // ==========================================================
    // Error flag events and clears
    // ==========================================================
    always_comb begin
        err_set = 3'h0;
        // Reset bit is loaded by reset, never by self-test
        err_set[`AFF_ERR_RST_BIT] = 1'b0;
        // Keeps setting while the fault is present
        err_set[`AFF_ERR_UVA_BIT] = st_q.uv_level && !lbist_active;
        err_set[`AFF_ERR_LOW_BIT] = field_low && !lbist_active;
        err_clr = {3{clr_err}};
    end

    aff_sticky #(
        .W(3),
        .RST_VAL(`AFF_ERR_RESET_VAL)
    ) u_err (
        .clk(clk),
        .rst_n(rst_n),
        .set(err_set),
        .clr(err_clr),
        .flags(err_q)
    );

    // ==========================================================
    // Warning flag events and clears
    // ==========================================================
    always_comb begin
        warn_set = 12'h000;
        warn_set[`AFF_W_IER_BIT] = pkt_done && ifc_fail;
        warn_set[`AFF_W_CRC_BIT] = pkt_done && !ifc_fail && crc_fail;
        warn_set[`AFF_W_SRW_BIT] = slew_limit_en && slew_limit_needed;
        warn_set[`AFF_W_XEE_BIT] = ext_cmd_done && (ext_locked || ext_nvm_fail);
        warn_set[`AFF_W_TR_BIT] = temp_oor;
        warn_set[`AFF_W_ESE_BIT] = nvm_load_active && nvm_single_corrected;
        warn_set[`AFF_W_SAT_BIT] = |sat_stage;
        warn_set[`AFF_W_TCW_BIT] = tc_fast;
        warn_set[`AFF_W_OVF_BIT] = ext_start && ext_busy;
        warn_set[`AFF_W_HIGH_BIT] = field_high;
        warn_set[`AFF_W_TOV_BIT] = turn_ovf;
        // Ordinary clear leaves turn overflow alone
        warn_clr = {12{clr_warn}};
        warn_clr[9] = 1'b0;
        warn_clr[`AFF_W_TOV_BIT] = turns_reset_cmd;
    end

    aff_sticky #(
        .W(12),
        .RST_VAL(12'h000)
    ) u_warn (
        .clk(clk),
        .rst_n(rst_n),
        .set(warn_set),
        .clr(warn_clr),
        .flags(warn_q)
    );

    // ==========================================================
    // Temperature readout
    // ==========================================================
    aff_temp #(
        .RAW_W(TEMP_RAW_W)
    ) u_temp (
        .clk(clk),
        .rst_n(rst_n),
        .temp_valid(temp_valid),
        .temp_raw(temp_raw),
        .temp_out(temp_word),
        .temp_oor(temp_oor)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        st_d = st_q;

        // Comparator input: three stages, level moves when last two agree
        st_d.uv_sync = {st_q.uv_sync[1:0], analog_undervolt_pin};
        if (st_q.uv_sync[1] == st_q.uv_sync[2]) begin
            st_d.uv_level = st_q.uv_sync[2];
        end

        // Thresholds follow configuration once it is loaded
        if (nvm_load_done) begin
            st_d.lo_lim = cfg_field_low_limit;
            st_d.hi_lim = cfg_field_high_limit;
        end

        // Reference angle for the next awake comparison
        if (!low_power_state) begin
            st_d.tc_prev_valid = 1'b0;
        end else if (awake_sample) begin
            st_d.tc_prev = zcd_angle;
            st_d.tc_prev_valid = 1'b1;
        end

        // Readout word, registered
        if (rd_en) begin
            case (rd_addr)
                `AFF_ERR_OFS: begin
                    st_d.rd_data = {`AFF_ERR_ID, err_upper, err_q};
                end
                `AFF_WARN_OFS: begin
                    st_d.rd_data = {`AFF_WARN_ID, warn_q[11:10], 1'b0, warn_q[8:0]};
                end
                `AFF_TEMP_OFS: begin
                    st_d.rd_data = {`AFF_TEMP_ID, temp_word};
                end
                default: begin
                    st_d.rd_data = 16'h0000;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q.uv_sync <= 3'h0;
            st_q.uv_level <= 1'b0;
            st_q.tc_prev <= 12'h000;
            st_q.tc_prev_valid <= 1'b0;
            st_q.lo_lim <= `AFF_FIELD_LO_DEF;
            st_q.hi_lim <= `AFF_FIELD_HI_DEF;
            st_q.rd_data <= 16'h0000;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign rd_data = st_q.rd_data;
    assign err_low_flags = err_q;
    assign warn_flags = {warn_q[11:10], 1'b0, warn_q[8:0]};

endmodule : aff_fault_flags

// *** aff_fault_flags_assertions.sv ***
/*
 * Concurrent checks on the ports of the fault flag block.
 * Assumes one clock and a synchronous active-low reset; bound below.
 */
`timescale 1ns/1ps
`include "aff_consts.svh"

module aff_fault_flags_chk #(
    parameter int SAT_W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic clr_warn,
    input wire logic turns_reset_cmd,
    // Events
    input wire logic lbist_active,
    input wire logic pkt_done,
    input wire logic [5:0] pkt_bits,
    input wire logic pkt_mosi_b15,
    input wire logic pkt_crc_bad,
    input wire logic rx_crc_check_en,
    input wire logic pkt_accept,
    input wire logic slew_limit_en,
    input wire logic slew_limit_needed,
    input wire logic [SAT_W-1:0] sat_stage,
    input wire logic turn_step_up,
    input wire logic turn_step_dn,
    // Flags
    input wire logic [2:0] err_low_flags,
    input wire logic [11:0] warn_flags
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Properties
    // ==========================================================
    a_reset_bit_set: assert property ($rose(rst_n) |-> err_low_flags == 3'h1)
        else $error("reset bit not set after reset");
    a_lbist_no_low: assert property (lbist_active && !err_low_flags[1] |=> !err_low_flags[1])
        else $error("low field set during self-test");
    a_ier_bad_len: assert property (pkt_done && !(pkt_bits inside {6'h10, 6'h14}) |=> warn_flags[11])
        else $error("bad length without interface warning");
    a_b15_drop: assert property (pkt_done && pkt_mosi_b15 |-> !pkt_accept ##1 warn_flags[11])
        else $error("bit 15 packet accepted");
    a_crc_drop: assert property (pkt_done && rx_crc_check_en && pkt_crc_bad |-> !pkt_accept)
        else $error("bad crc packet accepted");
    a_warn_sticky_hold: assert property (!clr_warn && !turns_reset_cmd
        |=> (warn_flags & $past(warn_flags)) == $past(warn_flags))
        else $error("warning dropped without clear");
    a_tov_keep: assert property (clr_warn && !turns_reset_cmd && warn_flags[0] |=> warn_flags[0])
        else $error("turn overflow cleared by warning clear");
    a_tov_clear: assert property (turns_reset_cmd && !turn_step_up && !turn_step_dn |=> !warn_flags[0])
        else $error("turn overflow not cleared");
    a_set_wins: assert property (clr_warn && (|sat_stage) |=> warn_flags[4])
        else $error("saturation lost on clear");
    a_slew_set: assert property (slew_limit_en && slew_limit_needed |=> warn_flags[8])
        else $error("slew warning missing");
    a_warn_word_id: assert property (rd_en && rd_addr == `AFF_WARN_OFS
        |=> rd_data[15:12] == `AFF_WARN_ID && !rd_data[9])
        else $error("warning word layout wrong");

    // ==========================================================
    // Coverage
    // ==========================================================
    c_tov: cover property (turn_step_up ##1 warn_flags[0]);
    c_set_wins: cover property (clr_warn && (|sat_stage));
    c_drop: cover property (pkt_done && !pkt_accept);
endmodule : aff_fault_flags_chk

bind aff_fault_flags aff_fault_flags_chk #(.SAT_W(SAT_W)) u_chk (.clk, .rst_n, .rd_en, .rd_addr, .rd_data,
    .clr_warn, .turns_reset_cmd, .lbist_active, .pkt_done, .pkt_bits, .pkt_mosi_b15, .pkt_crc_bad,
    .rx_crc_check_en, .pkt_accept, .slew_limit_en, .slew_limit_needed, .sat_stage, .turn_step_up,
    .turn_step_dn, .err_low_flags, .warn_flags);

// *** aff_host_model.sv ***
/*
 * Host side that reads flag words and issues clears.
 * Assumes its tasks are called at a falling edge of clk.
 */
`timescale 1ns/1ps

module aff_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic rd_en,
    output logic [7:0] rd_addr,
    input wire logic [15:0] rd_data,
    output logic clr_err,
    output logic clr_warn,
    output logic turns_reset_cmd
);
    initial begin
        {rd_en, clr_err, clr_warn, turns_reset_cmd} = 4'h0;
        rd_addr = 8'hFF;
    end

    // Word appears one edge after the request
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        rd_addr = ~a;
        d = rd_data;
    endtask : rd

    // Mask is {turns reset, warning clear, error clear}
    task automatic clr(input logic [2:0] m);
        @(negedge clk);
        {turns_reset_cmd, clr_warn, clr_err} = m;
        @(negedge clk);
        {turns_reset_cmd, clr_warn, clr_err} = 3'h0;
    endtask : clr
endmodule : aff_host_model

// *** angle_sensor_fault_flags_tb.sv ***
/*
 * Self-checking bench of the fault flag block.
 * Assumes the design, its constants and the host model are compiled first.
 */
`timescale 1ns/1ps

module angle_sensor_fault_flags_tb;
    logic clk, rst_n, rd_en, clr_err, clr_warn, turns_reset_cmd, analog_undervolt_pin, lbist_active;
    logic field_valid, nvm_load_active, nvm_load_done, rx_crc_check_en, nvm_single_corrected, pkt_done;
    logic pkt_mosi_b15, pkt_manchester_err, pkt_crc_bad, pkt_accept, slew_limit_en, slew_limit_needed;
    logic ext_start, ext_busy, ext_cmd_done, ext_locked, ext_nvm_fail, low_power_state, awake_sample;
    logic turn_res, turn_step_up, turn_step_dn, temp_valid;
    logic [7:0] rd_addr;
    logic [15:0] rd_data, d;
    logic [8:0] err_upper;
    logic [11:0] field_mag, cfg_field_low_limit, cfg_field_high_limit, zcd_angle, turn_count, warn_flags;
    logic [5:0] pkt_bits;
    logic [3:0] sat_stage;
    logic [13:0] temp_raw;
    logic [2:0] err_low_flags;
    int err_total = 0;
    int comparisons = 0;

    aff_fault_flags dut (.clk, .rst_n, .rd_en, .rd_addr, .rd_data, .clr_err, .clr_warn, .turns_reset_cmd,
        .err_upper, .analog_undervolt_pin, .lbist_active, .field_valid, .field_mag, .nvm_load_active,
        .nvm_load_done, .cfg_field_low_limit, .cfg_field_high_limit, .rx_crc_check_en, .nvm_single_corrected,
        .pkt_done, .pkt_bits, .pkt_mosi_b15, .pkt_manchester_err, .pkt_crc_bad, .pkt_accept, .slew_limit_en,
        .slew_limit_needed, .ext_start, .ext_busy, .ext_cmd_done, .ext_locked, .ext_nvm_fail, .sat_stage,
        .low_power_state, .awake_sample, .zcd_angle, .turn_res, .turn_count, .turn_step_up, .turn_step_dn,
        .temp_valid, .temp_raw, .err_low_flags, .warn_flags);
    aff_host_model host (.clk, .rd_en, .rd_addr, .rd_data, .clr_err, .clr_warn, .turns_reset_cmd);

    always #2 clk = ~clk;

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    // One edge with the event inputs, then drop the pulses
    task automatic tick;
        @(negedge clk);
        {pkt_done, slew_limit_needed, ext_start, ext_cmd_done, nvm_single_corrected, field_valid} = 6'h0;
        {temp_valid, awake_sample, turn_step_up, turn_step_dn, nvm_load_done} = 5'h0;
        sat_stage = 4'h0;
    endtask : tick

    task automatic wf(input logic [11:0] e);
        tick;
        chk("warn_set", warn_flags, e);
        host.clr(3'h2);
        chk("warn_clr", warn_flags, e & 12'h001);
    endtask : wf

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        conclude;
    end

    // ==========================================================
    // Sequence
    // ==========================================================
    initial begin
        {clk, rst_n, analog_undervolt_pin, lbist_active, nvm_load_active, rx_crc_check_en} = 6'h0;
        {pkt_mosi_b15, pkt_manchester_err, pkt_crc_bad, slew_limit_en, ext_busy, ext_locked} = 6'h0;
        {ext_nvm_fail, low_power_state, turn_res} = 3'h0;
        tick;
        err_upper = 9'h155;
        {cfg_field_low_limit, cfg_field_high_limit, field_mag} = {12'h0C8, 12'h4B0, 12'h300};
        {pkt_bits, zcd_angle, turn_count, temp_raw} = {6'h10, 12'h000, 12'h000, 14'h0000};
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk("err_low", err_low_flags, 3'h1);
        host.rd(8'h24, d); chk("err_word", d, {4'hA, 9'h155, 3'h1});
        host.rd(8'h26, d); chk("warn_word", d, 16'hB000);
        host.rd(8'h28, d); chk("temp_word", d, 16'hF000);
        host.rd(8'h2A, d); chk("unmapped", d, 16'h0000);
        host.clr(3'h1); chk("err_clr", err_low_flags, 3'h0);
        field_valid = 1'b1; field_mag = 12'h0C8; tick; chk("low_edge", err_low_flags, 3'h0);
        lbist_active = 1'b1; field_valid = 1'b1; field_mag = 12'h0C7; tick; chk("lbist", err_low_flags, 3'h0);
        lbist_active = 1'b0; field_valid = 1'b1; tick; chk("low_set", err_low_flags, 3'h2);
        host.clr(3'h1);
        cfg_field_low_limit = 12'h200; nvm_load_done = 1'b1; tick;
        field_valid = 1'b1; field_mag = 12'h1FF; tick; chk("low_cfg", err_low_flags, 3'h2);
        cfg_field_low_limit = 12'h0C8; nvm_load_done = 1'b1; tick;
        host.clr(3'h1);
        field_mag = 12'h300;
        analog_undervolt_pin = 1'b1;
        for (int i = 0; i < 10 && err_low_flags[2] !== 1'b1; i++) @(negedge clk);
        chk("uv_set", err_low_flags, 3'h4);
        host.clr(3'h1); chk("uv_held", err_low_flags, 3'h4);
        analog_undervolt_pin = 1'b0;
        repeat (6) @(negedge clk);
        host.clr(3'h1); chk("uv_clr", err_low_flags, 3'h0);
        err_upper = 9'h0AA;
        host.rd(8'h24, d); chk("err_up", d, {4'hA, 9'h0AA, 3'h0});
        pkt_done = 1'b1; pkt_bits = 6'h11; #1 chk("accept", pkt_accept, 1'b0); wf(12'h800);
        pkt_done = 1'b1; pkt_bits = 6'h10; pkt_mosi_b15 = 1'b1; wf(12'h800);
        pkt_mosi_b15 = 1'b0; pkt_done = 1'b1; pkt_manchester_err = 1'b1; wf(12'h800);
        pkt_manchester_err = 1'b0; pkt_crc_bad = 1'b1; pkt_done = 1'b1; #1 chk("accept", pkt_accept, 1'b1);
        wf(12'h000);
        rx_crc_check_en = 1'b1; pkt_done = 1'b1; #1 chk("accept", pkt_accept, 1'b0); wf(12'h400);
        pkt_bits = 6'h14; pkt_crc_bad = 1'b0; pkt_done = 1'b1; #1 chk("accept", pkt_accept, 1'b1); wf(12'h000);
        slew_limit_needed = 1'b1; wf(12'h000);
        slew_limit_en = 1'b1; slew_limit_needed = 1'b1; wf(12'h100);
        ext_cmd_done = 1'b1; wf(12'h000);
        ext_cmd_done = 1'b1; ext_locked = 1'b1; wf(12'h080);
        ext_locked = 1'b0; ext_nvm_fail = 1'b1; ext_cmd_done = 1'b1; wf(12'h080);
        nvm_single_corrected = 1'b1; wf(12'h000);
        nvm_load_active = 1'b1; nvm_single_corrected = 1'b1; wf(12'h020);
        nvm_load_active = 1'b0; sat_stage = 4'h8; wf(12'h010);
        ext_start = 1'b1; wf(12'h000);
        ext_busy = 1'b1; ext_start = 1'b1; wf(12'h004);
        field_valid = 1'b1; field_mag = 12'h4B0; wf(12'h000);
        field_valid = 1'b1; field_mag = 12'h4B1; wf(12'h002);
        cfg_field_high_limit = 12'h100; nvm_load_done = 1'b1; tick;
        field_valid = 1'b1; field_mag = 12'h101; wf(12'h002);
        temp_valid = 1'b1; temp_raw = 14'd1241; tick; wf(12'h040);
        host.rd(8'h28, d); chk("temp_hi", d, 16'hF4D8);
        temp_valid = 1'b1; temp_raw = 14'h3D57; tick; wf(12'h040);
        host.rd(8'h28, d); chk("temp_lo", d, 16'hFD58);
        temp_valid = 1'b1; temp_raw = 14'd1240; tick; wf(12'h000);
        host.rd(8'h28, d); chk("temp_in", d, 16'hF4D8);
        low_power_state = 1'b1; awake_sample = 1'b1; tick;
        awake_sample = 1'b1; zcd_angle = 12'h600; wf(12'h000);
        awake_sample = 1'b1; zcd_angle = 12'hC01; wf(12'h008);
        turn_count = 12'h1FF; turn_step_up = 1'b1; tick; chk("tov", warn_flags, 12'h001);
        host.clr(3'h2); chk("tov_keep", warn_flags, 12'h001);
        host.clr(3'h4); chk("tov_clr", warn_flags, 12'h000);
        turn_res = 1'b1; turn_step_up = 1'b1; tick; chk("tov_res", warn_flags, 12'h000);
        turn_count = 12'h800; turn_step_dn = 1'b1; tick; chk("tov_dn", warn_flags, 12'h001);
        sat_stage = 4'h1; host.clr(3'h2); chk("set_wins", warn_flags, 12'h011);
        host.rd(8'h26, d); chk("warn_word", d, 16'hB011);
        sat_stage = 4'h0; host.clr(3'h6); chk("all_clr", warn_flags, 12'h000);
        // Mid-run reset: reset bit returns, thresholds back to defaults
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk("err_rst", err_low_flags, 3'h1);
        field_valid = 1'b1; field_mag = 12'h101; tick; chk("hi_def", warn_flags, 12'h000);
        conclude;
    end
endmodule : angle_sensor_fault_flags_tb
